// ===== inc/adc_cal_pkg.sv
// constants, types and register selects for the a/d input calibration block
// assumes one 125 mhz clock and a simple word-write port from the protocol side
// Summary of operation
// - access key unlocks calibration register writes
// - writing zero to access relocks registers
// - zero trigger bits capture channel zero count
// - span trigger bits capture channel full-scale count
// - captured counts become coefficients at once
// - range endpoints normalise to plus/minus 20000
// - current ranges are bipolar converter sub-ranges
// - current variant always calibrates twenty milliamp range
// - auto uses 0V and +5V points only
// - shared option applies one channel's calibration
// - voltage config selects 5V or 10V range
// - calibration reset returns to zero step
package adc_cal_pkg;
	localparam logic [15:0] CAL_KEY      = 16'h5e2a;
	localparam logic [15:0] CAL_LOCK     = 16'h0000;
	localparam logic [2:0]  SEL_ACCESS   = 3'h0;
	localparam logic [2:0]  SEL_ZERO_TRG = 3'h1;
	localparam logic [2:0]  SEL_SPAN_TRG = 3'h2;
	localparam logic [2:0]  SEL_RANGE    = 3'h3;
	localparam logic [2:0]  SEL_MANUAL   = 3'h4;
	localparam logic [2:0]  SEL_SHARED   = 3'h5;
	localparam int          SHARED_EN_BIT = 8;
	localparam logic signed [15:0] NORM_FS   = 16'sh4e20;
	localparam logic signed [15:0] V10_FS    = 16'sh7fff;
	localparam logic signed [15:0] I20_FS    = 16'sh3333;
	localparam logic signed [15:0] SAT_MAX   = 16'sh7fff;
	localparam logic [7:0]  RANGE_RST    = 8'hff;
	localparam logic [7:0]  MANUAL_RST   = 8'h00;

	typedef enum logic [1:0] {
		ST_ZERO = 2'b01,
		ST_SPAN = 2'b10
	} step_t;

	typedef struct packed {
		logic [2:0]         chan;
		logic signed [15:0] count;
	} sample_t;
endpackage : adc_cal_pkg

// ===== src/count_normalizer.sv
// maps a raw count onto the normalised scale from a midpoint and a span
// assumes mid and span are stable in the cycle the sample is valid
`timescale 1ns/10ps
module count_normalizer
	import adc_cal_pkg::*;
(
	input  wire logic               clk_i,     // system clock
	input  wire logic               rst_n_i,   // sync reset, active low
	input  wire logic               valid_i,   // sample strobe
	input  wire sample_t            smp_i,     // raw sample
	input  wire logic signed [16:0] mid_i,     // count of range midpoint
	input  wire logic signed [17:0] span_i,    // count between endpoints
	output logic                    valid_o,   // normalised strobe
	output sample_t                 norm_o     // normalised sample
);
	wire logic signed [17:0] delta = 18'(smp_i.count) - 18'(mid_i);
	wire logic signed [35:0] num   = 36'(delta) * 36'(2 * NORM_FS);
	wire logic signed [35:0] quot  = (span_i > 18'sd0) ? num / 36'(span_i) : 36'sd0;
	// out-of-range inputs clip instead of wrapping
	wire logic signed [15:0] sat   = (quot > 36'(SAT_MAX)) ? SAT_MAX :
		(quot < -36'(SAT_MAX)) ? -SAT_MAX : quot[15:0];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			valid_o <= 1'b0;
			norm_o  <= '0;
		end else begin
			valid_o <= valid_i;
			norm_o  <= '{chan: smp_i.chan, count: sat};
		end
	end

	mid_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		valid_i && delta == 18'sd0 && span_i > 18'sd0 |=> valid_o && norm_o.count == 16'sh0000)
		else $error("midpoint did not normalise to zero");
endmodule : count_normalizer

// ===== src/adc_input_calibration.sv
// calibration control and count normalisation for eight multiplexed channels
// assumes samples arrive one per strobe tagged with their channel
`timescale 1ns/10ps
module adc_input_calibration
	import adc_cal_pkg::*;
#(
	parameter bit CURRENT_INPUT = 1'b0,  // 1 for the current-input variant
	parameter int CHANNELS      = 8      // channels on the port
) (
	input  wire logic               clk_i,        // system clock
	input  wire logic               rst_n_i,      // sync reset, active low
	input  wire logic               wr_i,         // register write strobe
	input  wire logic [2:0]         wr_sel_i,     // register select
	input  wire logic [15:0]        wr_data_i,    // register write data
	input  wire logic               cal_reset_i,  // restart calibration pulse
	input  wire logic               smp_valid_i,  // converter sample strobe
	input  wire sample_t            smp_i,        // converter sample
	input  wire logic signed [15:0] ref_zero_i,   // count at internal 0 V
	input  wire logic signed [15:0] ref_span_i,   // count at internal +5 V
	output logic                    unlocked_o,   // calibration writes allowed
	output step_t                   step_o,       // calibration step
	output logic [7:0]              zero_pend_o,  // zero captures waiting
	output logic [7:0]              span_pend_o,  // span captures waiting
	output logic                    norm_valid_o, // normalised strobe
	output sample_t                 norm_o        // normalised sample
);
	logic signed [15:0] lo_cnt [CHANNELS];
	logic signed [15:0] hi_cnt [CHANNELS];
	logic [7:0]         range_10v;
	logic [7:0]         manual;
	logic               shared_en;
	logic [2:0]         shared_src;
	step_t              next_step;

	function automatic logic signed [16:0] ext17(input logic signed [15:0] v);
		ext17 = {v[15], v};
	endfunction : ext17

	wire logic wr_access = wr_i && wr_sel_i == SEL_ACCESS;
	wire logic wr_zero   = wr_i && wr_sel_i == SEL_ZERO_TRG && unlocked_o;
	wire logic wr_span   = wr_i && wr_sel_i == SEL_SPAN_TRG && unlocked_o;
	wire logic wr_range  = wr_i && wr_sel_i == SEL_RANGE && unlocked_o;
	wire logic wr_manual = wr_i && wr_sel_i == SEL_MANUAL && unlocked_o;
	wire logic wr_shared = wr_i && wr_sel_i == SEL_SHARED && unlocked_o;

	wire logic [7:0] chan_bit = 8'(1) << smp_i.chan;
	wire logic       cap_zero = smp_valid_i && |(zero_pend_o & chan_bit);
	wire logic       cap_span = smp_valid_i && |(span_pend_o & chan_bit);
	// a trigger written in the capture cycle is kept: set wins over clear
	wire logic [7:0] next_zero_pend = cal_reset_i ? 8'h00 :
		(zero_pend_o & ~(cap_zero ? chan_bit : 8'h00)) | (wr_zero ? wr_data_i[7:0] : 8'h00);
	wire logic [7:0] next_span_pend = cal_reset_i ? 8'h00 :
		(span_pend_o & ~(cap_span ? chan_bit : 8'h00)) | (wr_span ? wr_data_i[7:0] : 8'h00);

	// coefficient selection; shared mode borrows the source channel
	wire logic [2:0] coef_ch    = shared_en ? shared_src : smp_i.chan;
	wire logic       use_manual = manual[coef_ch];
	wire logic signed [16:0] man_mid  = 17'((18'(lo_cnt[coef_ch]) + 18'(hi_cnt[coef_ch])) >>> 1);
	wire logic signed [17:0] man_span = 18'(hi_cnt[coef_ch]) - 18'(lo_cnt[coef_ch]);
	// auto: only the 0 V and +5 V points are measured, endpoints interpolated
	wire logic signed [16:0] ref_d    = ext17(ref_span_i) - ext17(ref_zero_i);
	wire logic signed [17:0] span_5v  = 18'(ref_d) <<< 1;
	wire logic signed [17:0] span_10v = 18'(ref_d) <<< 2;
	// 20 mA drives 4 V, so the bipolar span is 8/5 of the 0-to-5 V step
	wire logic signed [17:0] span_i20 = 18'((21'(ref_d) <<< 3) / 21'sd5);
	wire logic signed [17:0] auto_span = CURRENT_INPUT ? span_i20 :
		(range_10v[smp_i.chan] ? span_10v : span_5v);
	wire logic signed [16:0] sel_mid  = use_manual ? man_mid : ext17(ref_zero_i);
	wire logic signed [17:0] sel_span = use_manual ? man_span : auto_span;
	wire logic signed [15:0] rst_hi   = CURRENT_INPUT ? I20_FS : V10_FS;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			unlocked_o <= 1'b0;
		end else if (wr_access) begin
			unlocked_o <= (wr_data_i == CAL_KEY);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			zero_pend_o <= 8'h00;
			span_pend_o <= 8'h00;
			step_o      <= ST_ZERO;
		end else begin
			zero_pend_o <= next_zero_pend;
			span_pend_o <= next_span_pend;
			step_o      <= next_step;
		end
	end

	always_comb begin
		next_step = step_o;
		case (step_o)
			ST_ZERO: begin
				if (cap_zero) begin
					next_step = ST_SPAN;
				end
			end
			ST_SPAN: begin
				if (cap_span) begin
					next_step = ST_ZERO;
				end
			end
			default: next_step = ST_ZERO;
		endcase
		if (cal_reset_i) begin
			next_step = ST_ZERO;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			range_10v  <= RANGE_RST;
			manual     <= MANUAL_RST;
			shared_en  <= 1'b0;
			shared_src <= 3'h0;
		end else begin
			if (wr_range) begin
				range_10v <= wr_data_i[7:0];
			end
			if (wr_manual) begin
				manual <= wr_data_i[7:0];
			end
			if (wr_shared) begin
				shared_en  <= wr_data_i[SHARED_EN_BIT];
				shared_src <= wr_data_i[2:0];
			end
		end
	end

	// captured counts feed coefficients directly: no reload step
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < CHANNELS; i++) begin
				lo_cnt[i] <= -rst_hi;
				hi_cnt[i] <= rst_hi;
			end
		end else begin
			if (cap_zero) begin
				lo_cnt[smp_i.chan] <= smp_i.count;
			end
			if (cap_span) begin
				hi_cnt[smp_i.chan] <= smp_i.count;
			end
		end
	end

	count_normalizer u_norm (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.valid_i (smp_valid_i),
		.smp_i   (smp_i),
		.mid_i   (sel_mid),
		.span_i  (sel_span),
		.valid_o (norm_valid_o),
		.norm_o  (norm_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	key_unlock_a: assert property (wr_access && wr_data_i == CAL_KEY |=> unlocked_o)
		else $error("key did not unlock");
	zero_lock_a: assert property (wr_access && wr_data_i == CAL_LOCK |=> !unlocked_o ##1
		(!unlocked_o || $past(wr_access)))
		else $error("zero write did not relock");
	zero_trig_a: assert property (wr_zero && !cal_reset_i |=>
		(zero_pend_o & $past(wr_data_i[7:0])) == $past(wr_data_i[7:0]))
		else $error("zero trigger bits not pending");
	span_trig_a: assert property (wr_span && !cal_reset_i |=>
		(span_pend_o & $past(wr_data_i[7:0])) == $past(wr_data_i[7:0]))
		else $error("span trigger bits not pending");
	coef_update_a: assert property (cap_span |=> hi_cnt[$past(smp_i.chan)] == $past(smp_i.count))
		else $error("span count not stored at once");
	cur_range_a: assert property (CURRENT_INPUT && !use_manual
		|-> sel_span == 18'((8 * (int'(ref_span_i) - int'(ref_zero_i))) / 5))
		else $error("current variant used wrong range");
	volt_range_a: assert property (!CURRENT_INPUT && !use_manual && !range_10v[smp_i.chan]
		|-> sel_span == 18'(2 * (int'(ref_span_i) - int'(ref_zero_i))) && sel_mid == 17'(int'(ref_zero_i)))
		else $error("5 V auto span wrong");
	shared_coef_a: assert property (shared_en && manual[shared_src]
		|-> sel_span == 18'(int'(hi_cnt[shared_src]) - int'(lo_cnt[shared_src])))
		else $error("shared channel not applied");
	cal_restart_a: assert property (cal_reset_i |=> step_o == ST_ZERO && zero_pend_o == 8'h00
		&& span_pend_o == 8'h00)
		else $error("calibration reset not honoured");
	locked_trig_a: assert property (!unlocked_o && wr_i && wr_sel_i == SEL_SPAN_TRG && !smp_valid_i
		&& !cal_reset_i |=> $stable(span_pend_o))
		else $error("locked trigger accepted");
	norm_lat_a: assert property (smp_valid_i |=> norm_valid_o && norm_o.chan == $past(smp_i.chan))
		else $error("normalised sample lost");

	unlock_c:  cover property (wr_access && wr_data_i == CAL_KEY);
	zero_cap_c: cover property (cap_zero ##[1:20] cap_span);
	restart_c: cover property (step_o == ST_SPAN && cal_reset_i);
	shared_c:  cover property (shared_en && use_manual && smp_valid_i);
endmodule : adc_input_calibration

// ===== verification/cal_client_model.sv
// client-side model: word writes into the calibration registers
// assumes the block takes a write on the rising edge that sees wr_i high
`timescale 1ns/10ps
module cal_client_model (
	input  wire logic   clk_i,  // system clock
	output logic        wr_o,   // write strobe
	output logic [2:0]  sel_o,  // register select
	output logic [15:0] data_o  // write data
);
	initial begin
		wr_o = 1'b0;
		sel_o = 3'h0;
		data_o = 16'h0000;
	end

	task automatic write(input logic [2:0] sel, input logic [15:0] data);
		@(posedge clk_i);
		wr_o   <= 1'b1;
		sel_o  <= sel;
		data_o <= data;
		@(posedge clk_i);
		wr_o   <= 1'b0;
		// released bus shows junk, so a stale word cannot pass for a write
		data_o <= ~data;
	endtask : write
endmodule : cal_client_model

// ===== verification/adc_input_calibration_tb.sv
// self-checking bench for the calibration block, voltage and current variants
// assumes the client model alone drives the register write port
`timescale 1ns/10ps
module adc_input_calibration_tb;
	import adc_cal_pkg::*;
	logic               clk_i = 1'b0;
	logic               rst_n_i = 1'b0;
	logic               wr_i;
	logic [2:0]         wr_sel_i;
	logic [15:0]        wr_data_i;
	logic               cal_reset_i = 1'b0;
	logic               smp_valid_i = 1'b0;
	sample_t            smp_i = '0;
	logic signed [15:0] ref_zero_i = 16'sh0000;
	logic signed [15:0] ref_span_i = 16'sh4000;
	logic               unlocked_o;
	step_t              step_o;
	logic [7:0]         zero_pend_o;
	logic [7:0]         span_pend_o;
	logic               norm_valid_o;
	sample_t            norm_o;
	logic               cur_norm_valid;
	sample_t            cur_norm;
	int                 mismatches = 0;
	int                 tests_run = 0;

	adc_input_calibration dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .wr_sel_i(wr_sel_i),
		.wr_data_i(wr_data_i), .cal_reset_i(cal_reset_i), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
		.ref_zero_i(ref_zero_i), .ref_span_i(ref_span_i), .unlocked_o(unlocked_o), .step_o(step_o),
		.zero_pend_o(zero_pend_o), .span_pend_o(span_pend_o), .norm_valid_o(norm_valid_o), .norm_o(norm_o));
	// current variant shares every input; only its normalised result is judged
	adc_input_calibration #(.CURRENT_INPUT(1'b1)) dut_cur (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i),
		.wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .cal_reset_i(cal_reset_i), .smp_valid_i(smp_valid_i),
		.smp_i(smp_i), .ref_zero_i(ref_zero_i), .ref_span_i(ref_span_i), .unlocked_o(), .step_o(),
		.zero_pend_o(), .span_pend_o(), .norm_valid_o(cur_norm_valid), .norm_o(cur_norm));
	cal_client_model u_client (.clk_i(clk_i), .wr_o(wr_i), .sel_o(wr_sel_i), .data_o(wr_data_i));

	initial forever #4 clk_i = ~clk_i;

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_val

	task automatic chk_norm(input logic [2:0] chan, input logic signed [15:0] exp);
		tests_run++;
		if (norm_valid_o !== 1'b1 || norm_o !== {chan, exp}) begin
			mismatches++;
			$display("CHECK FAILED at %0t: norm got %h exp %h", $time, norm_o, {chan, exp});
		end
	endtask : chk_norm

	task automatic wr(input logic [2:0] sel, input logic [15:0] data);
		u_client.write(sel, data);
		#1;
	endtask : wr

	task automatic send(input logic [2:0] chan, input logic signed [15:0] count);
		@(posedge clk_i);
		smp_valid_i <= 1'b1;
		smp_i <= '{chan: chan, count: count};
		@(posedge clk_i);
		smp_valid_i <= 1'b0;
		#1;
	endtask : send

	task automatic t_locked;
		chk_val({15'h0000, unlocked_o}, 16'h0001 ^ 16'h0001, "locked");
		chk_val({14'h0000, step_o}, {14'h0000, ST_ZERO}, "step");
		wr(SEL_ZERO_TRG, 16'h00ff);
		chk_val({8'h00, zero_pend_o}, 16'h0000, "zero locked");
		wr(SEL_SPAN_TRG, 16'h00ff);
		chk_val({8'h00, span_pend_o}, 16'h0000, "span locked");
		wr(SEL_ACCESS, CAL_KEY);
		chk_val({15'h0000, unlocked_o}, 16'h0001, "unlock");
		$display("test locked done");
	endtask : t_locked

	task automatic t_auto;
		send(3'h1, 16'sh8000);
		chk_norm(3'h1, -NORM_FS);
		wr(SEL_RANGE, 16'h00fe);
		send(3'h0, 16'sh4000);
		chk_norm(3'h0, NORM_FS);
		send(3'h0, 16'she000);
		chk_norm(3'h0, 16'shd8f0);
		send(3'h0, 16'sh0000);
		chk_norm(3'h0, 16'sh0000);
		$display("test auto done");
	endtask : t_auto

	task automatic t_current;
		send(3'h0, 16'sh3333);
		chk_val({15'h0000, cur_norm_valid}, 16'h0001, "current valid");
		chk_val(cur_norm.count, NORM_FS, "current full scale");
		send(3'h1, 16'shcccd);
		chk_val(cur_norm.count, -NORM_FS, "current ignores range");
		$display("test current done");
	endtask : t_current

	task automatic t_capture;
		wr(SEL_MANUAL, 16'h0004);
		wr(SEL_ZERO_TRG, 16'hff04);
		chk_val({8'h00, zero_pend_o}, 16'h0004, "zero pend");
		send(3'h2, 16'sh8ad0);
		chk_val({8'h00, zero_pend_o}, 16'h0000, "zero taken");
		chk_val({14'h0000, step_o}, {14'h0000, ST_SPAN}, "step span");
		wr(SEL_SPAN_TRG, 16'h0004);
		chk_val({8'h00, span_pend_o}, 16'h0004, "span pend");
		send(3'h2, 16'sh7530);
		chk_val({8'h00, span_pend_o}, 16'h0000, "span taken");
		send(3'h2, 16'sh3a98);
		chk_norm(3'h2, 16'sh2710);
		send(3'h2, 16'sh8ad0);
		chk_norm(3'h2, -NORM_FS);
		$display("test capture done");
	endtask : t_capture

	task automatic t_shared;
		send(3'h5, 16'sh3a98);
		chk_norm(3'h5, 16'sh23c3);
		wr(SEL_SHARED, 16'h0102);
		send(3'h5, 16'sh3a98);
		chk_norm(3'h5, 16'sh2710);
		$display("test shared done");
	endtask : t_shared

	task automatic t_restart;
		wr(SEL_ZERO_TRG, 16'h00f0);
		wr(SEL_SPAN_TRG, 16'h000f);
		send(3'h4, 16'sh8ad0);
		chk_val({14'h0000, step_o}, {14'h0000, ST_SPAN}, "step before restart");
		@(posedge clk_i);
		cal_reset_i <= 1'b1;
		@(posedge clk_i);
		cal_reset_i <= 1'b0;
		#1;
		chk_val({zero_pend_o, span_pend_o}, 16'h0000, "pend cleared");
		chk_val({14'h0000, step_o}, {14'h0000, ST_ZERO}, "step zero");
		$display("test restart done");
	endtask : t_restart

	task automatic t_relock;
		wr(SEL_ACCESS, CAL_LOCK);
		chk_val({15'h0000, unlocked_o}, 16'h0000, "relock");
		wr(SEL_SPAN_TRG, 16'h0004);
		chk_val({8'h00, span_pend_o}, 16'h0000, "span ignored");
		send(3'h2, 16'sh3a98);
		chk_norm(3'h2, 16'sh2710);
		// a wrongly taken trigger would have moved the span by now
		send(3'h2, 16'sh3a98);
		chk_norm(3'h2, 16'sh2710);
		$display("test relock done");
	endtask : t_relock

	task automatic conclude;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_locked();
		t_auto();
		t_current();
		t_capture();
		t_shared();
		t_restart();
		t_relock();
		conclude();
	end

	// about 66 cycles expected; over twenty times that is a hang
	initial begin
		#12000;
		mismatches++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		conclude();
	end
endmodule : adc_input_calibration_tb
